// ===== src/mld_pkg.sv
// Package with register map, field layout, constants and types of the loopback diagnostics block.
package mld_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_COMMAND = 4'h0;
    localparam logic [3:0] ADDR_TRANSMIT_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_TRANSMIT_PAGE_START = 4'h2;
    localparam logic [3:0] ADDR_TRANSMIT_COUNT_LOW = 4'h3;
    localparam logic [3:0] ADDR_TRANSMIT_COUNT_HIGH = 4'h4;
    localparam logic [3:0] ADDR_FIFO_THRESHOLD = 4'h5;
    localparam logic [3:0] ADDR_INTERRUPT_STATUS = 4'h6;
    localparam logic [3:0] ADDR_TRANSMIT_STATUS = 4'h7;
    localparam logic [3:0] ADDR_RECEIVE_STATUS = 4'h8;
    localparam logic [3:0] ADDR_FIFO_READ = 4'h9;

    // Field positions.
    localparam int CMD_TRANSMIT_BIT = 0;
    localparam int CMD_BUSY_BIT = 1;
    localparam int TXC_CRC_INHIBIT_BIT = 0;
    localparam int TXC_LOOP_SELECT_LOW_BIT = 1;
    localparam int TXC_LOOP_SELECT_HIGH_BIT = 2;
    localparam int IST_PACKET_RECEIVED_BIT = 0;
    localparam int IST_PACKET_SENT_BIT = 1;
    localparam int TXS_CARRIER_LOST_BIT = 4;
    localparam int TXS_HEARTBEAT_FAIL_BIT = 6;
    localparam int RXS_INTACT_BIT = 0;
    localparam int RXS_CRC_ERROR_BIT = 1;

    // Reset values and fixed status patterns.
    localparam logic [7:0] TXC_RESET = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'h04;
    localparam logic [7:0] TXS_SENT_BASE = 8'h03;

    // Loopback select encodings.
    localparam logic [1:0] LOOP_NORMAL = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_CODEC = 2'h2;
    localparam logic [1:0] LOOP_EXTERNAL = 2'h3;

    // Framing and timing counts.
    localparam logic [6:0] PREAMBLE_BITS = 7'h38;
    localparam logic [6:0] SYNC_BITS = 7'h08;
    localparam logic [5:0] CRC_BITS = 6'h20;
    localparam logic [2:0] FIFO_SYNC_CLOCKS = 3'h4;

    // Frame check sequence, reflected form.
    localparam logic [31:0] CRC_POLY_REV = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

    // Transmitter and receiver states.
    typedef enum logic [4:0] {
        MLD_TX_IDLE = 5'b00001,
        MLD_TX_PREAMBLE = 5'b00010,
        MLD_TX_DATA = 5'b00100,
        MLD_TX_CRC = 5'b01000,
        MLD_TX_DONE = 5'b10000
    } mld_tx_state_t;

    typedef enum logic [4:0] {
        MLD_RX_HUNT = 5'b00001,
        MLD_RX_DATA = 5'b00010,
        MLD_RX_COUNT_LOW = 5'b00100,
        MLD_RX_COUNT_HIGH = 5'b01000,
        MLD_RX_COUNT_COPY = 5'b10000
    } mld_rx_state_t;

    // Buffer memory read request from the local DMA.
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } mld_mem_req_t;

endpackage

// ===== src/mld_loopback.sv
// Loopback diagnostics of the media access controller: DMA fill, serializer, receiver and split FIFO.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module mld_loopback #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register port.
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_wait_out,
    // Buffer memory read port of the local DMA.
    output mld_pkg::mld_mem_req_t mem_req_out,
    input wire logic mem_ack_in,
    input wire logic [7:0] mem_data_in,
    // Serial encoder/decoder path.
    output logic link_tx_data_out,
    output logic link_tx_en_out,
    input wire logic link_rx_data_in,
    input wire logic link_rx_dv_in,
    input wire logic link_col_in,
    input wire logic link_carrier_in,
    input wire logic link_ok_in,
    input wire logic twisted_pair_in,
    output logic codec_loop_control_out,
    // Address filter result for the frame being received.
    input wire logic addr_match_in
);
    import mld_pkg::*;

    localparam int HALF = FIFO_DEPTH / 2;
    localparam int HAW = $clog2(HALF);
    localparam int FAW = $clog2(FIFO_DEPTH);

    // One bit step of the reflected frame check sequence.
    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din);
        crc_step = (crc[0] ^ din) ? ((crc >> 1) ^ CRC_POLY_REV) : (crc >> 1);
    endfunction

    // Software registers.
    logic [7:0] txc_reg;
    logic [7:0] page_start_reg;
    logic [15:0] tx_count_reg;
    logic [7:0] threshold_reg;
    logic [7:0] ist_reg;
    logic [7:0] txs_reg;
    logic [7:0] rxs_reg;
    logic [7:0] rdata_reg;
    // FIFO storage; low half receives, high half transmits while looping back.
    logic [7:0] fifo_mem_reg [FIFO_DEPTH];
    // Transmit side.
    mld_tx_state_t tx_state_reg;
    logic [HAW:0] txf_wr_reg;
    logic [HAW:0] txf_rd_reg;
    logic [15:0] dma_offset_reg;
    logic dma_burst_reg;
    logic [6:0] pre_cnt_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_shift_reg;
    logic [5:0] crc_cnt_reg;
    logic [31:0] tx_crc_reg;
    logic tx_bit_out_reg;
    logic tx_active_reg;
    logic sense_seen_reg;
    logic col_seen_reg;
    // Receive side.
    mld_rx_state_t rx_state_reg;
    logic rx_prev_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic [HAW-1:0] rx_wr_reg;
    logic [15:0] rx_count_reg;
    logic [31:0] rx_crc_reg;
    logic match_reg;
    // Host FIFO read pointer and its synchronising delay.
    logic [HAW-1:0] host_ptr_reg;
    logic [2:0] sync_cnt_reg;
    logic codec_loop_reg;

    // Register decode and mode selection.
    wire logic [1:0] loop_sel = {txc_reg[TXC_LOOP_SELECT_HIGH_BIT], txc_reg[TXC_LOOP_SELECT_LOW_BIT]};
    wire logic loop_on = (loop_sel != LOOP_NORMAL);
    wire logic crc_inhibit = txc_reg[TXC_CRC_INHIBIT_BIT];
    wire logic wr_cmd = reg_wr_in && (reg_addr_in == ADDR_COMMAND);
    wire logic start_tx = wr_cmd && reg_wdata_in[CMD_TRANSMIT_BIT] && (tx_state_reg == MLD_TX_IDLE) && loop_on;
    wire logic rd_fifo = reg_rd_in && (reg_addr_in == ADDR_FIFO_READ);
    wire logic tx_busy = (tx_state_reg != MLD_TX_IDLE);

    // Transmit half occupancy and DMA request.
    wire logic [HAW:0] txf_level = txf_wr_reg - txf_rd_reg;
    wire logic txf_full = (txf_level == (HAW+1)'(HALF));
    wire logic txf_empty = (txf_level == '0);
    wire logic below_thresh = ({{(7-HAW){1'b0}}, txf_level} < threshold_reg);
    wire logic dma_want = tx_busy && (tx_count_reg != 16'h0000) && !txf_full && (dma_burst_reg || below_thresh);
    wire logic dma_take = dma_want && mem_ack_in;
    wire logic [FAW-1:0] txf_wr_loc = FAW'(HALF) + FAW'(txf_wr_reg[HAW-1:0]);
    wire logic [FAW-1:0] txf_rd_loc = FAW'(HALF) + FAW'(txf_rd_reg[HAW-1:0]);
    assign mem_req_out.rd = dma_want;
    assign mem_req_out.addr = {page_start_reg, 8'h00} + dma_offset_reg;

    // Transmitter sequencing terms.
    wire logic byte_edge = (tx_bit_reg == 3'h7);
    wire logic load_byte = (tx_state_reg == MLD_TX_DATA) && (tx_bit_reg == 3'h0) && !txf_empty;
    wire logic data_end = (tx_state_reg == MLD_TX_DATA) && (tx_bit_reg == 3'h0) && txf_empty;
    wire logic pre_end = (pre_cnt_reg == PREAMBLE_BITS + SYNC_BITS - 7'h01);
    // Preamble alternates one and zero; the sync pattern closes with two ones.
    wire logic pre_bit = pre_end ? 1'b1 : ~pre_cnt_reg[0];
    wire logic tx_bit_now = (tx_state_reg == MLD_TX_PREAMBLE) ? pre_bit :
                            (tx_state_reg == MLD_TX_CRC) ? ~tx_crc_reg[0] :
                            load_byte ? fifo_mem_reg[txf_rd_loc][0] : tx_shift_reg[0];
    wire logic tx_on_wire = (tx_state_reg == MLD_TX_PREAMBLE) || (tx_state_reg == MLD_TX_CRC) ||
                            load_byte || ((tx_state_reg == MLD_TX_DATA) && (tx_bit_reg != 3'h0));
    wire logic link_fail_block = (loop_sel == LOOP_EXTERNAL) && twisted_pair_in && !link_ok_in;

    // Receive source: internal loop bypasses the codec, other modes use the codec's receive path.
    wire logic rx_bit = (loop_sel == LOOP_INTERNAL) ? tx_bit_out_reg : link_rx_data_in;
    wire logic rx_dv = (loop_sel == LOOP_INTERNAL) ? tx_active_reg : link_rx_dv_in;
    wire logic rx_byte_done = (rx_state_reg == MLD_RX_DATA) && rx_dv && (rx_bit_reg == 3'h7);
    wire logic [7:0] rx_byte = {rx_bit, rx_shift_reg[7:1]};
    wire logic crc_bad = (rx_crc_reg != CRC_RESIDUE);
    wire logic crc_flag = match_reg && (crc_inhibit || crc_bad);
    wire logic rx_write = rx_byte_done || (rx_state_reg == MLD_RX_COUNT_LOW) ||
                          (rx_state_reg == MLD_RX_COUNT_HIGH) || (rx_state_reg == MLD_RX_COUNT_COPY);
    wire logic [7:0] rx_wdata = rx_byte_done ? rx_byte :
                                (rx_state_reg == MLD_RX_COUNT_LOW) ? rx_count_reg[7:0] : rx_count_reg[15:8];

    // Transmit status: carrier and heartbeat never reach the core in internal loop, heartbeat never in codec loop.
    wire logic txs_carrier = (loop_sel == LOOP_INTERNAL) || ((loop_sel == LOOP_EXTERNAL) && !sense_seen_reg);
    wire logic txs_heart = (loop_sel != LOOP_EXTERNAL) || !col_seen_reg;
    wire logic [7:0] txs_done = TXS_SENT_BASE | (8'(txs_carrier) << TXS_CARRIER_LOST_BIT) |
                                (8'(txs_heart) << TXS_HEARTBEAT_FAIL_BIT);

    // Read data selection.
    wire logic [7:0] rd_sel = (reg_addr_in == ADDR_COMMAND) ? (8'(tx_busy) << CMD_BUSY_BIT) :
                              (reg_addr_in == ADDR_TRANSMIT_CONFIG) ? txc_reg :
                              (reg_addr_in == ADDR_TRANSMIT_PAGE_START) ? page_start_reg :
                              (reg_addr_in == ADDR_TRANSMIT_COUNT_LOW) ? tx_count_reg[7:0] :
                              (reg_addr_in == ADDR_TRANSMIT_COUNT_HIGH) ? tx_count_reg[15:8] :
                              (reg_addr_in == ADDR_FIFO_THRESHOLD) ? threshold_reg :
                              (reg_addr_in == ADDR_INTERRUPT_STATUS) ? ist_reg :
                              (reg_addr_in == ADDR_TRANSMIT_STATUS) ? txs_reg :
                              (reg_addr_in == ADDR_RECEIVE_STATUS) ? rxs_reg :
                              rd_fifo ? fifo_mem_reg[FAW'(host_ptr_reg)] : 8'h00;

    // Configuration registers and transmit count.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            txc_reg <= TXC_RESET;
            page_start_reg <= 8'h00;
            threshold_reg <= THRESHOLD_RESET;
            tx_count_reg <= 16'h0000;
        end else begin
            if (reg_wr_in && (reg_addr_in == ADDR_TRANSMIT_CONFIG)) txc_reg <= reg_wdata_in;
            if (reg_wr_in && (reg_addr_in == ADDR_TRANSMIT_PAGE_START)) page_start_reg <= reg_wdata_in;
            if (reg_wr_in && (reg_addr_in == ADDR_FIFO_THRESHOLD)) threshold_reg <= reg_wdata_in;
            if (dma_take) begin
                tx_count_reg <= tx_count_reg - 16'h0001;
            end else if (reg_wr_in && (reg_addr_in == ADDR_TRANSMIT_COUNT_LOW)) begin
                tx_count_reg[7:0] <= reg_wdata_in;
            end else if (reg_wr_in && (reg_addr_in == ADDR_TRANSMIT_COUNT_HIGH)) begin
                tx_count_reg[15:8] <= reg_wdata_in;
            end
        end
    end

    // Interrupt and transmit status; a set in the same cycle as a clear wins.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ist_reg <= 8'h00;
            txs_reg <= 8'h00;
        end else begin
            if (reg_wr_in && (reg_addr_in == ADDR_INTERRUPT_STATUS)) ist_reg <= ist_reg & ~reg_wdata_in;
            if (tx_state_reg == MLD_TX_DONE) ist_reg[IST_PACKET_SENT_BIT] <= 1'b1;
            ist_reg[IST_PACKET_RECEIVED_BIT] <= 1'b0;
            if (start_tx) txs_reg <= 8'h00;
            else if (tx_state_reg == MLD_TX_DONE) txs_reg <= txs_done;
        end
    end

    // FIFO storage: DMA writes the transmit half, the receiver writes the receive half.
    always_ff @(posedge clock_in) begin
        if (dma_take) fifo_mem_reg[txf_wr_loc] <= mem_data_in;
        if (rx_write) fifo_mem_reg[FAW'(rx_wr_reg)] <= rx_wdata;
    end

    // Local DMA pointers and burst tracking.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in || start_tx) begin
            txf_wr_reg <= '0;
            dma_offset_reg <= 16'h0000;
            dma_burst_reg <= 1'b1;
        end else begin
            if (dma_take) begin
                txf_wr_reg <= txf_wr_reg + (HAW+1)'(1);
                dma_offset_reg <= dma_offset_reg + 16'h0001;
            end
            // A burst runs until the half is full, the next starts below threshold.
            if (txf_full) dma_burst_reg <= 1'b0;
            else if (below_thresh) dma_burst_reg <= 1'b1;
        end
    end

    // Transmitter state machine.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            tx_state_reg <= MLD_TX_IDLE;
            txf_rd_reg <= '0;
            pre_cnt_reg <= 7'h00;
            tx_bit_reg <= 3'h0;
            tx_shift_reg <= 8'h00;
            crc_cnt_reg <= 6'h00;
            tx_crc_reg <= CRC_INIT;
        end else begin
            case (tx_state_reg)
                MLD_TX_IDLE: begin
                    txf_rd_reg <= '0;
                    pre_cnt_reg <= 7'h00;
                    tx_bit_reg <= 3'h0;
                    tx_crc_reg <= CRC_INIT;
                    if (start_tx) tx_state_reg <= MLD_TX_PREAMBLE;
                end
                MLD_TX_PREAMBLE: begin
                    pre_cnt_reg <= pre_cnt_reg + 7'h01;
                    if (pre_end) tx_state_reg <= MLD_TX_DATA;
                end
                MLD_TX_DATA: begin
                    if (load_byte) begin
                        tx_shift_reg <= fifo_mem_reg[txf_rd_loc] >> 1;
                        txf_rd_reg <= txf_rd_reg + (HAW+1)'(1);
                        tx_bit_reg <= 3'h1;
                        tx_crc_reg <= crc_step(tx_crc_reg, tx_bit_now);
                    end else if (data_end) begin
                        // An empty half at a byte edge ends the data, as a short memory answer also would.
                        crc_cnt_reg <= 6'h00;
                        tx_state_reg <= crc_inhibit ? MLD_TX_DONE : MLD_TX_CRC;
                    end else begin
                        tx_shift_reg <= tx_shift_reg >> 1;
                        tx_bit_reg <= byte_edge ? 3'h0 : tx_bit_reg + 3'h1;
                        tx_crc_reg <= crc_step(tx_crc_reg, tx_bit_now);
                    end
                end
                MLD_TX_CRC: begin
                    tx_crc_reg <= tx_crc_reg >> 1;
                    crc_cnt_reg <= crc_cnt_reg + 6'h01;
                    if (crc_cnt_reg == CRC_BITS - 6'h01) tx_state_reg <= MLD_TX_DONE;
                end
                MLD_TX_DONE: tx_state_reg <= MLD_TX_IDLE;
                default: tx_state_reg <= MLD_TX_IDLE;
            endcase
        end
    end

    // Serial output stage, carrier and heartbeat observation.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            tx_bit_out_reg <= 1'b0;
            tx_active_reg <= 1'b0;
            sense_seen_reg <= 1'b0;
            col_seen_reg <= 1'b0;
        end else begin
            tx_bit_out_reg <= tx_on_wire && tx_bit_now;
            tx_active_reg <= tx_on_wire;
            if (start_tx) begin
                sense_seen_reg <= 1'b0;
                col_seen_reg <= 1'b0;
            end else if (tx_busy && (loop_sel == LOOP_EXTERNAL)) begin
                // The core only sees carrier and collision on the cable path; codec-made ones are masked.
                sense_seen_reg <= sense_seen_reg || link_carrier_in;
                col_seen_reg <= col_seen_reg || link_col_in;
            end
        end
    end

    // Frame leaves the device only on paths past the serializer, and never on a failed twisted-pair link in external loop.
    assign link_tx_data_out = tx_bit_out_reg && (loop_sel != LOOP_INTERNAL) && !link_fail_block;
    assign link_tx_en_out = tx_active_reg && (loop_sel != LOOP_INTERNAL) && !link_fail_block;

    // Receiver state machine.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rx_state_reg <= MLD_RX_HUNT;
            rx_prev_reg <= 1'b0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_wr_reg <= '0;
            rx_count_reg <= 16'h0000;
            rx_crc_reg <= CRC_INIT;
            match_reg <= 1'b0;
            rxs_reg <= 8'h00;
        end else begin
            case (rx_state_reg)
                MLD_RX_HUNT: begin
                    // Preamble is dropped; two ones in a row close the sync pattern.
                    rx_prev_reg <= rx_dv && rx_bit;
                    if (loop_on && rx_dv && rx_bit && rx_prev_reg) begin
                        rx_state_reg <= MLD_RX_DATA;
                        rx_bit_reg <= 3'h0;
                        rx_wr_reg <= '0;
                        rx_count_reg <= 16'h0000;
                        rx_crc_reg <= CRC_INIT;
                        match_reg <= addr_match_in;
                    end
                end
                MLD_RX_DATA: begin
                    if (rx_dv) begin
                        rx_shift_reg <= rx_byte;
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        rx_crc_reg <= crc_step(rx_crc_reg, rx_bit);
                        match_reg <= match_reg && addr_match_in;
                        if (rx_byte_done) begin
                            rx_wr_reg <= rx_wr_reg + HAW'(1);
                            rx_count_reg <= rx_count_reg + 16'h0001;
                        end
                    end else begin
                        rx_state_reg <= MLD_RX_COUNT_LOW;
                    end
                end
                MLD_RX_COUNT_LOW: begin
                    rx_wr_reg <= rx_wr_reg + HAW'(1);
                    rx_state_reg <= MLD_RX_COUNT_HIGH;
                end
                MLD_RX_COUNT_HIGH: begin
                    rx_wr_reg <= rx_wr_reg + HAW'(1);
                    rx_state_reg <= MLD_RX_COUNT_COPY;
                end
                MLD_RX_COUNT_COPY: begin
                    rx_wr_reg <= rx_wr_reg + HAW'(1);
                    rx_prev_reg <= 1'b0;
                    // Intact is reported whenever no CRC error is flagged, matching address or not.
                    rxs_reg <= (8'(!crc_flag) << RXS_INTACT_BIT) | (8'(crc_flag) << RXS_CRC_ERROR_BIT);
                    rx_state_reg <= MLD_RX_HUNT;
                end
                default: rx_state_reg <= MLD_RX_HUNT;
            endcase
        end
    end

    // Host read pointer: the oldest byte sits where the next write would go.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            host_ptr_reg <= '0;
            sync_cnt_reg <= 3'h0;
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd_in ? rd_sel : 8'h00;
            if (rx_state_reg == MLD_RX_COUNT_COPY) begin
                host_ptr_reg <= rx_wr_reg + HAW'(1);
                sync_cnt_reg <= 3'h0;
            end else if (rd_fifo && (sync_cnt_reg == 3'h0)) begin
                sync_cnt_reg <= FIFO_SYNC_CLOCKS;
            end else if (sync_cnt_reg != 3'h0) begin
                sync_cnt_reg <= sync_cnt_reg - 3'h1;
                if (sync_cnt_reg == 3'h1) host_ptr_reg <= host_ptr_reg + HAW'(1);
            end
        end
    end

    // Codec loop control is a registered decode of the select field.
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) codec_loop_reg <= 1'b0;
        else codec_loop_reg <= (loop_sel == LOOP_CODEC);
    end

    assign codec_loop_control_out = codec_loop_reg;
    assign reg_rdata_out = rdata_reg;
    // A FIFO read arriving before the pointer has moved is held off by wait states.
    assign reg_wait_out = rd_fifo && (sync_cnt_reg != 3'h0);

endmodule // mld_loopback

// ===== testbench/mld_far_model.sv
// Far-side model: buffer memory and the looping codec path.
`timescale 1ns/1ps
module mld_far_model (
    // Clock, memory port and codec path.
    input wire logic clock_in, slow_in, tx_data_in, tx_en_in, loop_in,
    input wire mld_pkg::mld_mem_req_t mem_req_in,
    output logic mem_ack_out, rx_data_out, rx_dv_out,
    output logic [7:0] mem_data_out
);
    import mld_pkg::*;
    logic tick_reg = 1'b0;
    // Slow mode answers every second cycle; idle lines keep moving.
    always_ff @(posedge clock_in) tick_reg <= ~tick_reg;
    assign mem_ack_out = mem_req_in.rd & (~slow_in | tick_reg);
    assign mem_data_out = mem_ack_out ? ~mem_req_in.addr[7:0] : {8{tick_reg}};
    // The codec hands the transmit side back to the receive side.
    assign rx_data_out = loop_in ? tx_data_in : tick_reg;
    assign rx_dv_out = loop_in & tx_en_in;
endmodule // mld_far_model

// ===== testbench/mld_assertions.sv
// Checker of the loopback diagnostics block ports.
`timescale 1ns/1ps
module mld_checker #(parameter int FIFO_DEPTH = 16) (
    // Clock, reset, register port and link side.
    input wire logic clock_in, rst_b_in, reg_wr_in, reg_rd_in, reg_wait_out, link_ok_in, twisted_pair_in,
    input wire logic link_tx_data_out, link_tx_en_out, codec_loop_control_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in, reg_rdata_out
);
    import mld_pkg::*;
    logic [1:0] sel_reg;
    // Shadow of the select field and the FIFO read strobe.
    wire logic [1:0] sel_next = reg_wr_in && reg_addr_in == ADDR_TRANSMIT_CONFIG ? reg_wdata_in[2:1] : sel_reg;
    wire logic fifo_rd = reg_rd_in && reg_addr_in == ADDR_FIFO_READ;
    always_ff @(posedge clock_in) sel_reg <= rst_b_in ? sel_next : LOOP_NORMAL;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // Loop control, link gating, preamble, wait states and read data.
    loop_on_a: assert property ($stable(sel_reg) && sel_reg == LOOP_CODEC |-> codec_loop_control_out)
        else $error("loop control low");
    loop_off_a: assert property ($stable(sel_reg) && sel_reg != LOOP_CODEC |-> !codec_loop_control_out)
        else $error("loop control high");
    inner_quiet_a: assert property (sel_reg == LOOP_INTERNAL |-> !link_tx_en_out)
        else $error("link driven");
    link_fail_a: assert property (sel_reg == LOOP_EXTERNAL && twisted_pair_in && !link_ok_in |-> !link_tx_en_out)
        else $error("sent on failed link");
    preamble_a: assert property ($rose(link_tx_en_out) |-> link_tx_data_out ##1 !link_tx_data_out ##1 link_tx_data_out)
        else $error("bad preamble");
    fifo_wait_a: assert property ((fifo_rd && !reg_wait_out) ##2 fifo_rd |-> reg_wait_out)
        else $error("no wait state");
    rx_flag_a: assert property ($past(reg_rd_in && reg_addr_in == ADDR_INTERRUPT_STATUS) |-> !reg_rdata_out[0])
        else $error("received flag set");
    idle_data_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("stray read data");
    cover property (fifo_rd ##2 fifo_rd);
    cover property ($rose(link_tx_en_out));
    cover property (codec_loop_control_out);
endmodule // mld_checker
bind mld_loopback mld_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clock_in, .rst_b_in, .reg_wr_in, .reg_rd_in,
    .reg_wait_out, .link_ok_in, .twisted_pair_in, .link_tx_data_out, .link_tx_en_out, .codec_loop_control_out,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out);

// ===== testbench/mld_loopback_bench.sv
// Self-checking bench of the loopback diagnostics block.
`timescale 1ns/1ps
module mld_loopback_bench;
    import mld_pkg::*;
    logic clock_in, rst_b_in, reg_wr_in, reg_rd_in, reg_wait_out, tx_d, tx_en, rx_d, rx_dv, ack, loop;
    logic match_reg, ok_reg, tp_reg, slow_reg, noise_reg;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, mem_data, q;
    mld_mem_req_t req;
    int err_total = 0;
    int n_tests = 0;
    logic [11:0] rows [11] = '{12'h743, 12'h802, 12'h602, 12'h9FF, 12'h9FE, 12'h9FD, 12'h9FC, 12'h9FB, 12'h905,
        12'h900, 12'h900};
    mld_loopback dut_u (.clock_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .reg_wait_out, .mem_req_out(req), .mem_ack_in(ack), .mem_data_in(mem_data), .link_tx_data_out(tx_d),
        .link_tx_en_out(tx_en), .link_rx_data_in(rx_d), .link_rx_dv_in(rx_dv), .link_col_in(noise_reg),
        .link_carrier_in(noise_reg), .link_ok_in(ok_reg), .twisted_pair_in(tp_reg), .codec_loop_control_out(loop),
        .addr_match_in(match_reg));
    mld_far_model far_u (.clock_in, .slow_in(slow_reg), .tx_data_in(tx_d), .tx_en_in(tx_en), .loop_in(loop),
        .mem_req_in(req), .mem_ack_out(ack), .rx_data_out(rx_d), .rx_dv_out(rx_dv), .mem_data_out(mem_data));
    // Free-running clock.
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    // One-cycle read strobe; the data are taken in the following cycle and compared when asked.
    task automatic rc(input logic [3:0] a, input logic [7:0] e, input bit c = 1'b1);
        @(posedge clock_in);
        {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(negedge clock_in);
        q = reg_rdata_out;
        n_tests += c;
        if (c && q !== e) begin
            err_total++;
            $display("ERROR %0t read %h want %h", $time, q, e);
        end
    endtask
    // Start a five-byte frame, leaving the select field through normal, and, when w is set, wait for the sent flag.
    task automatic go(input logic [7:0] cfg, input bit w = 1'b1);
        wr(ADDR_TRANSMIT_CONFIG, TXC_RESET);
        wr(ADDR_TRANSMIT_CONFIG, cfg);
        wr(ADDR_TRANSMIT_COUNT_LOW, 8'h05);
        wr(ADDR_COMMAND, 8'h01);
        for (int i = 0; i < 300 && w; i++) begin
            rc(ADDR_INTERRUPT_STATUS, 8'h00, 1'b0);
            if (q[IST_PACKET_SENT_BIT] === 1'b1) return;
        end
        if (!w) return;
        $display("ERROR %0t no sent flag", $time);
        err_total++;
        results();
    endtask
    // Verdict and end of run.
    task automatic results;
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Codec loop table, then internal and external loop cases.
    initial begin
        {rst_b_in, reg_wr_in, reg_rd_in, slow_reg, tp_reg, reg_addr_in, reg_wdata_in} = '0;
        {match_reg, ok_reg, noise_reg} = 3'h7;
        repeat (3) @(posedge clock_in);
        rst_b_in <= 1'b1;
        go(8'h05);
        foreach (rows[i]) begin
            if (i > 3 && i < 10) repeat (3) @(posedge clock_in);
            rc(rows[i][11:8], rows[i][7:0]);
        end
        wr(ADDR_INTERRUPT_STATUS, 8'h02);
        {match_reg, slow_reg} <= 2'h1;
        go(8'h03);
        rc(ADDR_TRANSMIT_STATUS, 8'h53);
        rc(ADDR_RECEIVE_STATUS, 8'h01);
        rc(ADDR_TRANSMIT_COUNT_LOW, 8'h00);
        wr(ADDR_INTERRUPT_STATUS, 8'h02);
        {tp_reg, ok_reg} <= 2'h2;
        go(8'h07, 1'b0);
        repeat (200) @(posedge clock_in);
        // Mid-run reset returns the registers to their reset values.
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rc(ADDR_TRANSMIT_CONFIG, TXC_RESET);
        rc(ADDR_FIFO_THRESHOLD, THRESHOLD_RESET);
        rc(ADDR_INTERRUPT_STATUS, 8'h00);
        results();
    end
endmodule // mld_loopback_bench
